// ---- crs_defs.vh ----
// Constants for the processor register set block
// Overview of operation
// - Thirteen registers, seven duplicated in two banks
// - Four 16-bit data regs, all byte-splittable
// - Data pairs concatenate into 32-bit operands
// - Address regs as data, pointers, 32-bit pair
// - 16-bit frame base register
// - 20-bit instruction pointer
// - 20-bit vector table base register
// - Two stack pointers, flag selects active one
// - 16-bit static base register
// - Flag word holds eleven implemented bits
// - Bit 0 captures carry, borrow, shift-out
// - Bit 1 single-step, cleared on acknowledge
// - Bit 2 set on zero result
// - Bit 3 set on negative result
// - Bit 4 selects register bank
// - Bit 5 set on overflow
// - Bit 6 gates interrupts, cleared on acknowledge
// - Bit 7 stack select, cleared on interrupt or trap 0-31
// - Bits 8 to 11 reserved
// - Bits 12 to 14 hold priority level
// - Priority level three bits, levels 0-7
// - Accept interrupt only above current level
// - Bit 15 reserved
`ifndef CRS_DEFS_VH
`define CRS_DEFS_VH
// Register indices (word offset = index * 4)
`define CRS_IDX_DAT0  4'h0
`define CRS_IDX_DAT1  4'h1
`define CRS_IDX_DAT2  4'h2
`define CRS_IDX_DAT3  4'h3
`define CRS_IDX_ADR0  4'h4
`define CRS_IDX_ADR1  4'h5
`define CRS_IDX_FRM   4'h6
`define CRS_IDX_IPTR  4'h7
`define CRS_IDX_VTB   4'h8
`define CRS_IDX_USTK  4'h9
`define CRS_IDX_ISTK  4'ha
`define CRS_IDX_SBASE 4'hb
`define CRS_IDX_FLAGS 4'hc
`define CRS_IDX_SP    4'hd
`define CRS_IDX_IRQ   4'he
// Flag word fields
`define CRS_F_C       0
`define CRS_F_D       1
`define CRS_F_Z       2
`define CRS_F_S       3
`define CRS_F_B       4
`define CRS_F_O       5
`define CRS_F_I       6
`define CRS_F_U       7
`define CRS_F_LVL_LO  12
`define CRS_F_LVL_HI  14
`define CRS_FLAG_MASK 16'h70ff
`define CRS_FLAG_RST  16'h0000
`define CRS_TRAP_LAST 6'h1f
`endif

// ---- crs_regset.v ----
// Processor register set with flag word and register bus
//
// Chosen here: the Wishbone register port and the register addresses.
`timescale 1ns/10ps
`include "crs_defs.vh"
module crs_regset (
  // Clock and reset
  input  wire        clk,
  input  wire        rst_n,
  // Wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  output reg         wb_err_o,
  // Core write port
  input  wire        core_we,
  input  wire [3:0]  core_idx,
  input  wire [1:0]  core_byte_en,
  input  wire [19:0] core_wdata,
  input  wire        core_long_we,
  input  wire [1:0]  core_long_sel,
  input  wire [31:0] core_long_wdata,
  input  wire        pc_load,
  input  wire [19:0] pc_next,
  // ALU status
  input  wire        alu_upd,
  input  wire        alu_carry,
  input  wire        alu_zero,
  input  wire        alu_neg,
  input  wire        alu_ovf,
  // Interrupt sequencing
  input  wire        insn_done,
  input  wire        irq_req,
  input  wire [2:0]  irq_level,
  input  wire        irq_ack,
  input  wire        trap_exec,
  input  wire [5:0]  trap_num,
  input  wire        step_ack,
  // Register views
  output reg  [31:0] long_data_pair_low,
  output reg  [31:0] long_data_pair_high,
  output reg  [31:0] long_addr_pair,
  output reg  [15:0] frame_base_reg,
  output reg  [15:0] static_base_reg,
  output reg  [15:0] active_stack_ptr,
  output reg  [19:0] instr_pointer,
  output reg  [19:0] vector_table_base,
  output reg  [15:0] processor_flag_word,
  output reg         irq_accept,
  output reg         step_irq
);

  // Banked registers: bank*7 + index (data 0-3, address 0-1, frame)
  reg [15:0] bank_q [0:13];
  reg [15:0] ustk_q;
  reg [15:0] istk_q;
  reg [15:0] sbase_q;
  reg [19:0] iptr_q;
  reg [19:0] vtb_q;
  reg [15:0] flag_q;
  reg [15:0] flag_d;

  wire       bsel = flag_q[`CRS_F_B];
  wire [3:0] boff = bsel ? 4'h7 : 4'h0;

  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire [3:0] bus_idx = wb_adr_i[5:2];
  wire bus_map = (bus_idx <= `CRS_IDX_IRQ);
  wire bus_wr = bus_req & wb_we_i & bus_map;
  wire [15:0] bus_w16 = {wb_sel_i[1] ? wb_dat_i[15:8] : 8'h00,
                         wb_sel_i[0] ? wb_dat_i[7:0]  : 8'h00};

  // Read mux of current bank view
  reg [31:0] rd_val;
  always @* begin
    rd_val = 32'h0000_0000;
    case (bus_idx)
      `CRS_IDX_DAT0, `CRS_IDX_DAT1, `CRS_IDX_DAT2, `CRS_IDX_DAT3,
      `CRS_IDX_ADR0, `CRS_IDX_ADR1, `CRS_IDX_FRM:
        rd_val = {16'h0000, bank_q[boff + bus_idx]};
      `CRS_IDX_IPTR:  rd_val = {12'h000, iptr_q};
      `CRS_IDX_VTB:   rd_val = {12'h000, vtb_q};
      `CRS_IDX_USTK:  rd_val = {16'h0000, ustk_q};
      `CRS_IDX_ISTK:  rd_val = {16'h0000, istk_q};
      `CRS_IDX_SBASE: rd_val = {16'h0000, sbase_q};
      `CRS_IDX_FLAGS:
        rd_val = {16'h0000, flag_q & `CRS_FLAG_MASK};
      `CRS_IDX_SP:
        rd_val = {16'h0000, flag_q[`CRS_F_U] ? ustk_q : istk_q};
      `CRS_IDX_IRQ:  rd_val = {30'h0000_0000, step_irq, irq_accept};
      default:       rd_val = 32'h0000_0000;
    endcase
  end

  // Bus slave: one-cycle ack, err for unmapped
  always @(posedge clk) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= bus_req & bus_map;
      wb_err_o <= bus_req & ~bus_map;
      wb_dat_o <= (bus_req & bus_map & ~wb_we_i) ? rd_val : 32'h0000_0000;
    end
  end

  // Per-entry write logic for banked registers
  genvar g;
  generate
    for (g = 0; g < 14; g = g + 1) begin : g_bank
      localparam integer GI = g % 7;
      wire       gb = (g >= 7);
      wire [3:0] gi = GI[3:0];
      wire       hit_core = core_we & (gb == bsel) & (core_idx == gi);
      wire       hit_bus = bus_wr & (gb == bsel) & (bus_idx == gi);
      wire       lp_lo = (gi == 4'h0) | (gi == 4'h2);
      wire       lp_hi = (gi == 4'h1) | (gi == 4'h3);
      wire       lp_ad = (gi == 4'h4) | (gi == 4'h5);
      wire       hi_half = (gi == 4'h2) | (gi == 4'h3) | (gi == 4'h5);
      wire       hit_long = core_long_we & (gb == bsel) &
                   ((core_long_sel == 2'h0 & lp_lo) |
                    (core_long_sel == 2'h1 & lp_hi) |
                    (core_long_sel == 2'h2 & lp_ad));
      always @(posedge clk) begin
        if (!rst_n) begin
          bank_q[g] <= 16'h0000;
        end else if (hit_long) begin
          bank_q[g] <= hi_half ? core_long_wdata[31:16]
                               : core_long_wdata[15:0];
        end else if (hit_core) begin
          if (core_byte_en[1])
            bank_q[g][15:8] <= core_wdata[15:8];
          if (core_byte_en[0])
            bank_q[g][7:0] <= core_wdata[7:0];
        end else if (hit_bus) begin
          if (wb_sel_i[1])
            bank_q[g][15:8] <= wb_dat_i[15:8];
          if (wb_sel_i[0])
            bank_q[g][7:0] <= wb_dat_i[7:0];
        end
      end
    end
  endgenerate

  // Shared registers, unaffected by bank select
  wire core16 = core_we & (core_byte_en == 2'h3);
  always @(posedge clk) begin
    if (!rst_n) begin
      ustk_q  <= 16'h0000;
      istk_q  <= 16'h0000;
      sbase_q <= 16'h0000;
      iptr_q  <= 20'h00000;
      vtb_q   <= 20'h00000;
    end else begin
      if (core16 & core_idx == `CRS_IDX_USTK)
        ustk_q <= core_wdata[15:0];
      else if (bus_wr & bus_idx == `CRS_IDX_USTK)
        ustk_q <= bus_w16;
      else if (core16 & core_idx == `CRS_IDX_SP & flag_q[`CRS_F_U])
        ustk_q <= core_wdata[15:0];
      if (core16 & core_idx == `CRS_IDX_ISTK)
        istk_q <= core_wdata[15:0];
      else if (bus_wr & bus_idx == `CRS_IDX_ISTK)
        istk_q <= bus_w16;
      else if (core16 & core_idx == `CRS_IDX_SP & ~flag_q[`CRS_F_U])
        istk_q <= core_wdata[15:0];
      if (core16 & core_idx == `CRS_IDX_SBASE)
        sbase_q <= core_wdata[15:0];
      else if (bus_wr & bus_idx == `CRS_IDX_SBASE)
        sbase_q <= bus_w16;
      if (pc_load)
        iptr_q <= pc_next;
      else if (bus_wr & bus_idx == `CRS_IDX_IPTR)
        iptr_q <= wb_dat_i[19:0];
      if (core16 & core_idx == `CRS_IDX_VTB)
        vtb_q <= core_wdata;
      else if (bus_wr & bus_idx == `CRS_IDX_VTB)
        vtb_q <= wb_dat_i[19:0];
    end
  end

  // Flag word next value
  wire irq_ok = irq_req & flag_q[`CRS_F_I] &
                (irq_level > flag_q[`CRS_F_LVL_HI:`CRS_F_LVL_LO]);
  wire trap_lo = trap_exec & (trap_num <= `CRS_TRAP_LAST);
  always @* begin
    flag_d = flag_q;
    if (core16 & core_idx == `CRS_IDX_FLAGS)
      flag_d = core_wdata[15:0];
    else if (bus_wr & bus_idx == `CRS_IDX_FLAGS)
      flag_d = bus_w16;
    if (alu_upd) begin
      flag_d[`CRS_F_C] = alu_carry;
      flag_d[`CRS_F_Z] = alu_zero;
      flag_d[`CRS_F_S] = alu_neg;
      flag_d[`CRS_F_O] = alu_ovf;
    end
    if (step_ack)
      flag_d[`CRS_F_D] = 1'b0;
    if (irq_ack) begin
      flag_d[`CRS_F_I] = 1'b0;
      flag_d[`CRS_F_U] = 1'b0;
    end
    if (trap_lo)
      flag_d[`CRS_F_U] = 1'b0;
    flag_d = flag_d & `CRS_FLAG_MASK;
  end

  always @(posedge clk) begin
    if (!rst_n)
      flag_q <= `CRS_FLAG_RST;
    else
      flag_q <= flag_d;
  end

  // Registered views
  always @(posedge clk) begin
    if (!rst_n) begin
      long_data_pair_low  <= 32'h0000_0000;
      long_data_pair_high <= 32'h0000_0000;
      long_addr_pair      <= 32'h0000_0000;
      frame_base_reg      <= 16'h0000;
      static_base_reg     <= 16'h0000;
      active_stack_ptr    <= 16'h0000;
      instr_pointer       <= 20'h00000;
      vector_table_base   <= 20'h00000;
      processor_flag_word <= 16'h0000;
      irq_accept          <= 1'b0;
      step_irq            <= 1'b0;
    end else begin
      long_data_pair_low  <= {bank_q[boff + 4'h2],
                              bank_q[boff]};
      long_data_pair_high <= {bank_q[boff + 4'h3],
                              bank_q[boff + 4'h1]};
      long_addr_pair      <= {bank_q[boff + 4'h5],
                              bank_q[boff + 4'h4]};
      frame_base_reg      <= bank_q[boff + 4'h6];
      static_base_reg     <= sbase_q;
      active_stack_ptr    <= flag_q[`CRS_F_U] ? ustk_q : istk_q;
      instr_pointer       <= iptr_q;
      vector_table_base   <= vtb_q;
      processor_flag_word <= flag_q;
      irq_accept          <= irq_ok;
      step_irq            <= insn_done & flag_q[`CRS_F_D];
    end
  end

endmodule

// ---- crs_regset_assertions.sv ----
// Checker of flag word and bus answer timing
`timescale 1ns/10ps
module crs_regset_chk (
  input wire        clk,
  input wire        rst_n,
  input wire        wb_stb_i,
  input wire        wb_we_i,
  input wire        wb_ack_o,
  input wire        core_we,
  input wire        alu_upd,
  input wire        alu_carry,
  input wire        alu_zero,
  input wire        alu_neg,
  input wire        alu_ovf,
  input wire        insn_done,
  input wire        irq_req,
  input wire [2:0]  irq_level,
  input wire        irq_ack,
  input wire        trap_exec,
  input wire [5:0]  trap_num,
  input wire        step_ack,
  input wire [15:0] processor_flag_word,
  input wire        irq_accept,
  input wire        step_irq
);
  wire [15:0] f = processor_flag_word;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_ack2; irq_ack ##2 1'b1; endsequence
  sequence s_trap2; trap_exec && trap_num <= 6'h1f ##2 1'b1; endsequence
  a_rsvd_zero: assert property ((f & 16'h8f00) == 16'h0000)
    else $error("reserved flag bits not zero");
  a_one_ack: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_step_irq: assert property (insn_done |=> step_irq == f[1])
    else $error("single step request wrong");
  a_step_clr: assert property (step_ack |-> ##2 !f[1])
    else $error("debug flag not cleared");
  a_irq_clr: assert property (s_ack2 |-> !f[6] && !f[7])
    else $error("enable or stack flag kept on acknowledge");
  a_trap_clr: assert property (s_trap2 |-> !f[7])
    else $error("stack flag kept on low trap");
  a_irq_gate: assert property (
    irq_accept == ($past(irq_req) && f[6] && $past(irq_level) > f[14:12]))
    else $error("interrupt accept wrong");
  a_alu_flags: assert property (
    alu_upd && !core_we && !(wb_stb_i && wb_we_i) |-> ##2
    {f[0], f[2], f[3], f[5]} ==
    {$past(alu_carry, 2), $past(alu_zero, 2), $past(alu_neg, 2),
    $past(alu_ovf, 2)})
    else $error("status flags not loaded");
endmodule
bind crs_regset crs_regset_chk u_chk (.clk(clk), .rst_n(rst_n),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o),
  .core_we(core_we), .alu_upd(alu_upd), .alu_carry(alu_carry),
  .alu_zero(alu_zero), .alu_neg(alu_neg), .alu_ovf(alu_ovf),
  .insn_done(insn_done), .irq_req(irq_req), .irq_level(irq_level),
  .irq_ack(irq_ack), .trap_exec(trap_exec), .trap_num(trap_num),
  .step_ack(step_ack), .processor_flag_word(processor_flag_word),
  .irq_accept(irq_accept), .step_irq(step_irq));

// ---- tb_crs_regset.sv ----
// Self-checking bench of the register set
`timescale 1ns/10ps
module tb_crs_regset;
  reg         clk, rst_n, cyc, we, c_we, c_lwe, pc_ld, au, ac, az, an, ao;
  reg         idn, irq, iak, trp, sak;
  reg  [5:0]  adr, tn;
  reg  [3:0]  sel, c_idx;
  reg  [1:0]  c_be, c_ls;
  reg  [2:0]  ilv;
  reg  [19:0] c_wd, pcn;
  reg  [31:0] wd, c_ld, r;
  reg  [33:0] n;
  reg  [19:0] m [0:11];
  reg  [33:0] q [$];
  wire [31:0] rd, ldl, ldh, lap;
  wire [15:0] frm_v, sbs_v, sp, flags_v;
  wire [19:0] ip, vtb;
  wire        ack, err, acc, sti;
  integer     err_total, total_checks, i;
  crs_regset DUT (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd),
    .wb_dat_o(rd), .wb_ack_o(ack), .wb_err_o(err), .core_we(c_we),
    .core_idx(c_idx), .core_byte_en(c_be), .core_wdata(c_wd),
    .core_long_we(c_lwe), .core_long_sel(c_ls), .core_long_wdata(c_ld),
    .pc_load(pc_ld), .pc_next(pcn), .alu_upd(au), .alu_carry(ac),
    .alu_zero(az), .alu_neg(an), .alu_ovf(ao), .insn_done(idn),
    .irq_req(irq), .irq_level(ilv), .irq_ack(iak), .trap_exec(trp),
    .trap_num(tn), .step_ack(sak), .long_data_pair_low(ldl),
    .long_data_pair_high(ldh), .long_addr_pair(lap),
    .frame_base_reg(frm_v), .static_base_reg(sbs_v),
    .active_stack_ptr(sp), .instr_pointer(ip),
    .vector_table_base(vtb), .processor_flag_word(flags_v),
    .irq_accept(acc), .step_irq(sti));
  function [31:0] nx(input [31:0] v);
    nx = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task check(input [31:0] s, input [31:0] e);
    total_checks = total_checks + 1;
    if (s !== e) begin
      err_total = err_total + 1;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task wrap_up;
    $display("checks=%0d errors=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // One classic cycle; the note says what the answer must be
  task bus(input w, input [3:0] x, input [31:0] d, input [3:0] s,
           input [32:0] e);
    integer k;
    q.push_back({~w, e});
    @(posedge clk);
    {cyc, we, adr, wd, sel} <= {1'b1, w, x, 2'b00, d, s};
    for (k = 0; k < 20 && !(ack | err); k = k + 1)
      @(posedge clk);
    cyc <= 1'b0;
    if (k == 20) begin
      err_total = err_total + 1;
      wrap_up;
    end
  endtask
  always @(posedge clk)
    if (ack | err) begin
      n = q.pop_front();
      check(err, n[32]);
      if (n[33]) check(rd, n[31:0]);
    end
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial begin
    {rst_n, cyc, we, adr, sel, wd} = 0;
    {c_we, c_idx, c_be, c_wd, c_lwe, c_ls, c_ld, pc_ld, pcn} = 0;
    {au, ac, az, an, ao, idn, irq, ilv, iak, trp, tn, sak} = 0;
    err_total = 0;
    total_checks = 0;
    r = 32'h364a;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 4'hc, 0, 4'hf, 0);
    bus(1, 4'hc, 32'hffffffff, 4'hf, 0);
    bus(0, 4'hc, 0, 4'hf, 33'h70ff);
    bus(1, 4'hc, 0, 4'hf, 0);
    for (i = 0; i < 12; i = i + 1) begin
      r = nx(r);
      m[i] = (i == 7 || i == 8) ? r[19:0] : {4'h0, r[15:0]};
      bus(1, i[3:0], r, 4'hf, 0);
    end
    for (i = 0; i < 12; i = i + 1)
      bus(0, i[3:0], 0, 4'hf, {13'h0, m[i]});
    check(ldl, {m[2][15:0], m[0][15:0]});
    check(ldh, {m[3][15:0], m[1][15:0]});
    check(lap, {m[5][15:0], m[4][15:0]});
    check({frm_v, sbs_v}, {m[6][15:0], m[11][15:0]});
    check(sp, {16'h0, m[10][15:0]});
    check(ip, m[7]);
    check(vtb, m[8]);
    bus(1, 4'hc, 32'h10, 4'hf, 0);
    for (i = 0; i < 12; i = i + 1)
      bus(0, i[3:0], 0, 4'hf, {13'h0, i < 7 ? 20'h0 : m[i]});
    bus(1, 4'hc, 32'h80, 4'hf, 0);
    bus(0, 4'hd, 0, 4'hf, {13'h0, m[9]});
    r = nx(r);
    bus(1, 4'h1, r, 4'h2, 0);
    bus(0, 4'h1, 0, 4'hf, {17'h0, r[15:8], m[1][7:0]});
    bus(1, 4'hf, r, 4'hf, 33'h100000000);
    bus(0, 4'hc, 0, 4'hf, 33'h80);
    bus(1, 4'hc, 32'h42, 4'hf, 0);
    @(posedge clk);
    {irq, ilv, idn} <= 5'b1_011_1;
    @(posedge clk);
    idn <= 1'b0;
    @(posedge clk);
    check(flags_v, 32'h42);
    check(acc, 1);
    check(sti, 1);
    repeat (400) begin
      @(posedge clk);
      r = nx(r);
      {c_we, c_idx, c_be, c_lwe, c_ls, pc_ld, au, ac, az, an, ao, idn,
        irq, ilv, iak, trp, tn, sak} <= r[29:0];
      c_wd <= r[31:12];
      pcn <= r[19:0];
      c_ld <= {r[15:0], r[31:16]};
    end
    @(posedge clk);
    {c_we, c_lwe, pc_ld, au, idn, irq, iak, trp, sak} <= 0;
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus(0, 4'hc, 0, 4'hf, 0);
    wrap_up;
  end
endmodule
